// ---- src/ccsr_top.sv ----
`timescale 1ns/10ps
`include "ccsr_params.svh"
// ==========================================
module ccsr_top
	import ccsr_pkg::*;
#(
	parameter logic [2:0] PLATFORM_CODE = 3'h0, // board-dependent code
	parameter logic [3:0] L2_LATENCY = 4'h1 // cache read latency figure
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic [`CCSR_ADDR_W-1:0] ADDR,
	input wire logic [63:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [63:0] RDATA,
	input wire logic BOOTSTRAP_STRAP,
	input wire logic CLK_RATIO_STRAP,
	input wire logic TRISTATE_STRAP,
	input wire logic BIST_STRAP,
	input wire logic APERR_OBS_STRAP,
	output logic INTC_ENABLE,
	output logic [31:0] INTC_BASE_ADDR,
	output logic DATA_CHECK_EN,
	output logic RESP_CHECK_EN,
	output logic MASTER_CHECKER_OBS_EN,
	output logic APERR_DRIVE_EN,
	output logic BUS_ERROR_SIGNAL_INITIATOR_EN,
	output logic BUS_ERROR_SIGNAL_INTERNAL_EN,
	output logic BUS_INIT_SIGNAL_DRIVE_EN,
	output logic APERR_OBS_EN
);
	// ==========================================
	// internal wiring
	ccsr_sel_t sel; // one-hot register select
	ccsr_wr_if wbus (); // write strobes and data
	logic intc_en_q; // global enable
	logic [`CCSR_BASE_MSB-`CCSR_BASE_LSB:0] base_q; // base address high bits
	logic [7:0] pon_q; // writable power-on bits, low byte
	logic [7:0] pon_d;
	logic [4:0] strap_q; // straps caught after reset release
	logic strap_done_q; // straps captured once
	ccsr_word_t plat_word; // platform identification view
	ccsr_word_t intc_word; // interrupt controller base view
	ccsr_word_t pon_word; // power-on configuration view
	ccsr_word_t rd_mux; // selected read value
	logic [63:0] rdata_q;

	// ==========================================
	// decode
	ccsr_decode u_dec (
		.addr(ADDR),
		.wr(WR),
		.wdata(WDATA),
		.sel(sel),
		.wbus(wbus)
	);

	// ==========================================
	// interrupt controller base holder
	ccsr_intc_base u_intc (
		.CLK(CLK),
		.RST(RST),
		.wbus(wbus),
		.enable_q(intc_en_q),
		.base_q(base_q)
	);

	// ==========================================
	// straps: captured by a clocked process after reset, never by the reset itself
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			strap_q <= 5'h00;
			strap_done_q <= 1'b0;
		end else if (!strap_done_q) begin
			strap_q <= {APERR_OBS_STRAP, BIST_STRAP, TRISTATE_STRAP,
				CLK_RATIO_STRAP, BOOTSTRAP_STRAP};
			strap_done_q <= 1'b1;
		end
	end

	// ==========================================
	// writable power-on bits; reserved and read-only positions masked off
	assign pon_d = wbus.wr_pon ? (wbus.wdata[7:0] & 8'(`CCSR_PON_RW_MASK)) : pon_q;
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			pon_q <= `CCSR_PON_RESET;
		end else begin
			pon_q <= pon_d;
		end
	end

	// ==========================================
	// read views; everything not assigned reads as zero
	always_comb begin
		plat_word = '0;
		plat_word[`CCSR_PLAT_CODE_MSB:`CCSR_PLAT_CODE_LSB] = PLATFORM_CODE;
		plat_word[`CCSR_L2LAT_MSB:`CCSR_L2LAT_LSB] = L2_LATENCY;
		plat_word[`CCSR_CLKRATIO_BIT] = strap_q[1];
	end
	always_comb begin
		intc_word = '0;
		intc_word[`CCSR_BSP_BIT] = strap_q[0];
		intc_word[`CCSR_GEN_BIT] = intc_en_q;
		intc_word[`CCSR_BASE_MSB:`CCSR_BASE_LSB] = base_q;
	end
	always_comb begin
		pon_word = '0;
		pon_word[7:0] = pon_q;
		pon_word[`CCSR_PON_TRISTATE] = strap_q[2];
		pon_word[`CCSR_PON_BIST] = strap_q[3];
		pon_word[`CCSR_PON_APERR_OBS] = strap_q[4];
	end

	// ==========================================
	// read mux; unmapped addresses answer zero
	always_comb begin
		unique case (sel)
			CCSR_SEL_PLAT: begin
				rd_mux = plat_word;
			end
			CCSR_SEL_INTC: begin
				rd_mux = intc_word;
			end
			CCSR_SEL_PON: begin
				rd_mux = pon_word;
			end
			CCSR_SEL_NONE: begin
				rd_mux = '0;
			end
			default: begin
				rd_mux = '0;
			end
		endcase
	end

	// read data stands only in the cycle after the strobe, zero otherwise
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rdata_q <= 64'h0;
		end else begin
			rdata_q <= RD ? rd_mux : 64'h0;
		end
	end
	assign RDATA = rdata_q;

	// ==========================================
	// feature controls driven straight from the flops
	assign INTC_ENABLE = intc_en_q;
	assign INTC_BASE_ADDR = {base_q, 12'h000};
	assign DATA_CHECK_EN = pon_q[`CCSR_PON_DATACHK];
	assign RESP_CHECK_EN = pon_q[`CCSR_PON_RESPCHK];
	assign MASTER_CHECKER_OBS_EN = pon_q[`CCSR_PON_RESPCHK];
	assign APERR_DRIVE_EN = pon_q[`CCSR_PON_APERR_DRV];
	assign BUS_ERROR_SIGNAL_INITIATOR_EN = pon_q[`CCSR_PON_BUS_ERROR_SIGNAL_INIT];
	assign BUS_ERROR_SIGNAL_INTERNAL_EN = pon_q[`CCSR_PON_BUS_ERROR_SIGNAL_INT];
	assign BUS_INIT_SIGNAL_DRIVE_EN = pon_q[`CCSR_PON_BUS_INIT_SIGNAL_DRV];
	assign APERR_OBS_EN = strap_q[4];
endmodule

// ---- include/ccsr_params.svh ----
`ifndef CCSR_PARAMS_SVH
`define CCSR_PARAMS_SVH
// ==========================================
// register indices and bus address width
`define CCSR_IDX_PLATFORM 8'h17
`define CCSR_IDX_INTC_BASE 8'h1B
`define CCSR_IDX_POWERON 8'h2A
`define CCSR_ADDR_W 10
// ==========================================
// platform identification fields
`define CCSR_PLAT_CODE_LSB 50
`define CCSR_PLAT_CODE_MSB 52
`define CCSR_L2LAT_LSB 53
`define CCSR_L2LAT_MSB 56
`define CCSR_CLKRATIO_BIT 60
// ==========================================
// local interrupt controller base fields
`define CCSR_BSP_BIT 8
`define CCSR_GEN_BIT 11
`define CCSR_BASE_LSB 12
`define CCSR_BASE_MSB 31
`define CCSR_BASE_RESET 20'hFEE00
// ==========================================
// hard power-on configuration fields
`define CCSR_PON_DATACHK 1
`define CCSR_PON_RESPCHK 2
`define CCSR_PON_APERR_DRV 3
`define CCSR_PON_BUS_ERROR_SIGNAL_INIT 4
`define CCSR_PON_BUS_ERROR_SIGNAL_INT 6
`define CCSR_PON_BUS_INIT_SIGNAL_DRV 7
`define CCSR_PON_TRISTATE 8
`define CCSR_PON_BIST 9
`define CCSR_PON_APERR_OBS 10
`define CCSR_PON_RW_MASK 64'h0000_0000_0000_00DE
`define CCSR_PON_RESET 8'h00
`endif

// ---- include/ccsr_pkg.sv ----
package ccsr_pkg;
	// ==========================================
	// register select, one-hot
	typedef enum logic [3:0] {
		CCSR_SEL_NONE = 4'h1,
		CCSR_SEL_PLAT = 4'h2,
		CCSR_SEL_INTC = 4'h4,
		CCSR_SEL_PON = 4'h8
	} ccsr_sel_t;
	typedef logic [63:0] ccsr_word_t;
endpackage

// ---- include/ccsr_wr_if.sv ----
`timescale 1ns/10ps
// write path between the decoder and the register holders
interface ccsr_wr_if;
	logic wr_intc; // write hits the interrupt controller base
	logic wr_pon; // write hits the power-on configuration
	logic [63:0] wdata; // write data
	modport dec (output wr_intc, output wr_pon, output wdata);
	modport reg_side (input wr_intc, input wr_pon, input wdata);
endinterface

// ---- src/ccsr_decode.sv ----
`timescale 1ns/10ps
`include "ccsr_params.svh"
// address decode for the register bus
module ccsr_decode
	import ccsr_pkg::*;
(
	input wire logic [`CCSR_ADDR_W-1:0] addr,
	input wire logic wr,
	input wire logic [63:0] wdata,
	output ccsr_sel_t sel,
	ccsr_wr_if.dec wbus
);
	// ==========================================
	// decode function, shared by read and write
	function automatic ccsr_sel_t dec_f(input logic [`CCSR_ADDR_W-1:0] a);
		ccsr_sel_t s;
		s = CCSR_SEL_NONE;
		if (a == {`CCSR_IDX_PLATFORM, 2'h0}) begin
			s = CCSR_SEL_PLAT;
		end else if (a == {`CCSR_IDX_INTC_BASE, 2'h0}) begin
			s = CCSR_SEL_INTC;
		end else if (a == {`CCSR_IDX_POWERON, 2'h0}) begin
			s = CCSR_SEL_PON;
		end
		return s;
	endfunction
	assign sel = dec_f(addr);
	// writes to the read-only platform word or unmapped space are dropped
	assign wbus.wr_intc = wr && (sel == CCSR_SEL_INTC);
	assign wbus.wr_pon = wr && (sel == CCSR_SEL_PON);
	assign wbus.wdata = wdata;
endmodule

// ---- src/ccsr_intc_base.sv ----
`timescale 1ns/10ps
`include "ccsr_params.svh"
// local interrupt controller base register holder
module ccsr_intc_base (
	input wire logic CLK,
	input wire logic RST,
	ccsr_wr_if.reg_side wbus,
	output logic enable_q,
	output logic [`CCSR_BASE_MSB-`CCSR_BASE_LSB:0] base_q
);
	// ==========================================
	// global enable: once cleared, only reset brings it back
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			enable_q <= 1'b1;
		end else if (wbus.wr_intc && !wbus.wdata[`CCSR_GEN_BIT]) begin
			enable_q <= 1'b0;
		end
	end
	// ==========================================
	// base address, 4 KB aligned so only bits 31:12 are kept
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			base_q <= `CCSR_BASE_RESET;
		end else if (wbus.wr_intc) begin
			base_q <= wbus.wdata[`CCSR_BASE_MSB:`CCSR_BASE_LSB];
		end
	end
endmodule

// ---- verif/ccsr_props.sv ----
`timescale 1ns/10ps
`include "ccsr_params.svh"
// ==========================================
// pin-level relations of the register bank
module ccsr_props (
	input wire logic CLK,
	input wire logic RST,
	input wire logic [`CCSR_ADDR_W-1:0] ADDR,
	input wire logic [63:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [63:0] RDATA,
	input wire logic INTC_ENABLE,
	input wire logic DATA_CHECK_EN,
	input wire logic RESP_CHECK_EN,
	input wire logic MASTER_CHECKER_OBS_EN,
	input wire logic APERR_OBS_EN
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	// a read strobe at one word, answered in the next cycle
	sequence rd_at(logic [9:0] a);
		RD && ADDR == a;
	endsequence
	// a write strobe at the power-on word
	sequence wr_pon;
		WR && ADDR == 10'h0A8;
	endsequence
	AST_IDLE_ZERO: assert property (!$past(RD) |-> RDATA == 64'h0)
		else $error("read data not zero outside answer cycle");
	AST_EN_STICKY: assert property (!INTC_ENABLE |=> !INTC_ENABLE)
		else $error("global enable came back without reset");
	AST_EN_READ: assert property (rd_at(10'h06C) |=> RDATA[11] == INTC_ENABLE)
		else $error("enable bit read differs from enable pin");
	AST_BIT2_PAIR: assert property (RESP_CHECK_EN == MASTER_CHECKER_OBS_EN)
		else $error("bit 2 enables disagree");
	AST_DCHK_WR: assert property (wr_pon |=> DATA_CHECK_EN == $past(WDATA[1]))
		else $error("data check enable not taken from write");
	AST_RESP_WR: assert property (wr_pon |=> RESP_CHECK_EN == $past(WDATA[2]))
		else $error("response check enable not taken from write");
	AST_PLAT_RSV: assert property (rd_at(10'h05C) |=> RDATA[49:0] == 50'h0 &&
		RDATA[59:57] == 3'h0 && RDATA[63:61] == 3'h0)
		else $error("platform reserved bits not zero");
	AST_INTC_RSV: assert property (rd_at(10'h06C) |=> RDATA[63:32] == 32'h0 &&
		RDATA[7:0] == 8'h00 && RDATA[10:9] == 2'h0)
		else $error("base word reserved bits not zero");
	AST_OBS_READ: assert property (rd_at(10'h0A8) |=> RDATA[10] == $past(APERR_OBS_EN))
		else $error("parity observation bit differs from pin");
endmodule
bind ccsr_top ccsr_props u_props (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
	.WR(WR), .RD(RD), .RDATA(RDATA), .INTC_ENABLE(INTC_ENABLE),
	.DATA_CHECK_EN(DATA_CHECK_EN), .RESP_CHECK_EN(RESP_CHECK_EN),
	.MASTER_CHECKER_OBS_EN(MASTER_CHECKER_OBS_EN), .APERR_OBS_EN(APERR_OBS_EN));

// ---- verif/tb.sv ----
`timescale 1ns/10ps
module tb;
	import ccsr_pkg::*;
	// ==========================================
	// bus drive and observed pins
	logic clk = 0, rst = 1, wr = 0, rd = 0; // strobes idle low
	logic [9:0] addr = 0;
	ccsr_word_t wdata = 0, rdata, got, d, p = 0; // p: last power-on word
	logic [31:0] r = 32'hb4a0, base; // r: random state
	logic [4:0] st = 0; // strap levels, fixed after reset
	logic [8:0] en; // enable pins gathered
	int num_errors = 0, samples_checked = 0;
	always #5 clk = ~clk;
	ccsr_top #(.PLATFORM_CODE(3'h5), .L2_LATENCY(4'hA)) dut (
		.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .BOOTSTRAP_STRAP(st[0]), .CLK_RATIO_STRAP(st[1]),
		.TRISTATE_STRAP(st[2]), .BIST_STRAP(st[3]), .APERR_OBS_STRAP(st[4]),
		.INTC_ENABLE(en[0]), .INTC_BASE_ADDR(base), .DATA_CHECK_EN(en[1]),
		.RESP_CHECK_EN(en[2]), .MASTER_CHECKER_OBS_EN(en[3]), .APERR_DRIVE_EN(en[4]),
		.BUS_ERROR_SIGNAL_INITIATOR_EN(en[5]), .BUS_ERROR_SIGNAL_INTERNAL_EN(en[6]), .BUS_INIT_SIGNAL_DRIVE_EN(en[7]),
		.APERR_OBS_EN(en[8]));
	// ==========================================
	// expectations
	function automatic logic [31:0] nxt(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic ccsr_word_t plat_exp();
		return {3'h0, st[1], 3'h0, 4'hA, 3'h5, 50'h0};
	endfunction
	function automatic ccsr_word_t intc_exp(logic e, logic [19:0] b);
		return {32'h0, b, e, 2'h0, st[0], 8'h00};
	endfunction
	function automatic ccsr_word_t pon_exp(ccsr_word_t v);
		return (v & 64'h0000_0000_0000_00DE) | {53'h0, st[4:2], 8'h00};
	endfunction
	function automatic logic [8:0] pins_exp(ccsr_word_t v, logic e);
		return {st[4], v[7], v[6], v[4], v[3], v[2], v[2], v[1], e};
	endfunction
	// ==========================================
	// bus cycles: entered just after an edge, so they chain with no gap
	task automatic wrw(logic [9:0] a, ccsr_word_t v);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// read data is taken mid-cycle, away from the edge that updates it
	task automatic rdw(logic [9:0] a);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		got = rdata;
		@(posedge clk);
	endtask
	task automatic chk_word(ccsr_word_t g, ccsr_word_t e);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %0t word %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk_pins(logic [8:0] g, logic [8:0] e);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %0t pins %b expected %b", $time, g, e);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// watchdog: a hang counts as a mismatch
	initial begin
		repeat (2000) @(posedge clk);
		num_errors++;
		finish_test();
	end
	// ==========================================
	// main sequence
	initial begin
		st = r[15:11]; // mixed strap levels, not all zero
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		rdw(10'h05C);
		chk_word(got, plat_exp());
		rdw(10'h06C);
		chk_word(got, intc_exp(1'b1, 20'hFEE00));
		chk_pins(en, pins_exp(p, 1'b1));
		$display("test reset done");
		// all ones and all zeros first, then random words
		for (int i = 0; i < 12; i++) begin
			r = nxt(r);
			d = (i == 0) ? '1 : (i == 1) ? '0 : {r, nxt(r)};
			p = d;
			wrw(10'h0A8, d);
			rdw(10'h0A8);
			chk_word(got, pon_exp(d));
			chk_pins(en, pins_exp(d, 1'b1));
		end
		$display("test poweron done");
		d = {r, nxt(r)};
		d[11] = 1'b0;
		// clear the enable, then try to set it again
		for (int i = 0; i < 2; i++) begin
			wrw(10'h06C, d);
			rdw(10'h06C);
			chk_word(got, intc_exp(1'b0, d[31:12]));
			chk_pins(en, pins_exp(p, 1'b0));
			chk_word({32'h0, base}, {32'h0, d[31:12], 12'h000});
			d[11] = 1'b1;
		end
		$display("test enable done");
		wrw(10'h05C, '1);
		wrw(10'h3FC, '1);
		rdw(10'h3FC);
		chk_word(got, '0);
		rdw(10'h05C);
		chk_word(got, plat_exp());
		$display("test refused done");
		finish_test();
	end
endmodule
